// ---- pkg/codec_ctrl_pkg.sv ----
// Constants, register map and types of the voice codec control block
package codec_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] PWR_CTRL_OFS = 8'h00;
  localparam logic [7:0] TX_GAIN_OFS  = 8'h04;
  localparam logic [7:0] RX_GAIN_OFS  = 8'h08;
  localparam logic [7:0] FORMAT_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS   = 8'h10;

  // Power control fields
  localparam int PWR_ON_BIT       = 0;
  localparam int PWR_EAR_DIFF_BIT = 1;
  localparam int PWR_EAR_MUTE_BIT = 3;
  localparam int PWR_MIC_MUTE_BIT = 6;
  localparam int PWR_ST_MUTE_BIT  = 7;

  // Transmit gain / sidetone fields
  localparam int TX_CODE_LSB       = 0;
  localparam int TX_ST_LSB         = 4;
  localparam int TX_CLKDET_OFF_BIT = 7;

  // Receive gain fields
  localparam int RX_CODE_LSB = 0;
  localparam int RX_TONE_BIT = 4;

  // Format fields
  localparam int FMT_LINEAR_BIT = 0;
  localparam int FMT_ALAW_BIT   = 1;

  // Status fields
  localparam int STAT_POWERED_BIT = 0;
  localparam int STAT_CLK_OK_BIT  = 1;
  localparam int STAT_BUSY_BIT    = 2;
  localparam int STAT_TX_OK_BIT   = 3;
  localparam int STAT_RX_OK_BIT   = 4;
  localparam int STAT_DRAIN_BIT   = 5;

  // Reset values
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_GAIN_RST  = 8'h0B;
  localparam logic [7:0] RX_GAIN_RST  = 8'h0A;
  localparam logic [7:0] FORMAT_RST   = 8'h00;

  // Sample word sizes
  localparam logic [3:0] LINEAR_BITS  = 4'hF;
  localparam logic [3:0] COMPAND_BITS = 4'h8;

  // Companding limits
  localparam logic [12:0] MU_CLIP = 13'h1FDE;
  localparam logic [12:0] MU_BIAS = 13'h0021;
  localparam logic [11:0] A_CLIP  = 12'hFFF;

  // Receive and transmit gain limits
  localparam logic [3:0] RX_VOICE_MAX = 4'hC;
  localparam logic [3:0] RX_TONE_MAX  = 4'hE;
  localparam logic [2:0] TX_STEP_MAX  = 3'h5;

  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int RESET_MIN_NS   = 500;
  localparam int RESET_MIN_CYC  = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int MCLK_LOSS_NS   = 2000;
  localparam int MCLK_LOSS_CYC  = (MCLK_LOSS_NS * CLK_MHZ) / 1000;
  localparam int DRAIN_HOLD_NS  = 2000;
  localparam int DRAIN_HOLD_CYC = (DRAIN_HOLD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_DRAIN} pwr_state_t;

endpackage

// ---- core/voice_codec_power_gain_control.sv ----
// Voice codec control: registers, power sequencing, gain decode, serial sample output
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - External reset loads every register default.
// - Settings writable while powered down.
// - Bit 1 picks differential or single-ended earphone.
// - Clearing power bit 0 powers down.
// - Master clock loss forces power-down, output released.
// - Word in flight completes before power-down.
// - Tx bit 7 bypasses master clock detection.
// - Linear 15-bit or companded 8-bit words.
// - Companded codes follow G.711 mu-law, A-law.
// - Linear words are two's complement.
// - Power bit 6 mutes the microphone.
// - Tx code selects extended/normal mode and step.
// - Tx gain code resets to 1011.
// - Rx codes 0..12 give +6..-6 dB.
// - Rx gain code resets to 1010.
// - Tone mode gain in groups of three.
// - MSB first, change after rise, release after.
module voice_codec_power_gain_control
  import codec_ctrl_pkg::*;
#(
  parameter int MCLK_LOSS_CYCLES  = MCLK_LOSS_CYC,
  parameter int DRAIN_HOLD_CYCLES = DRAIN_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Master clock pin
  input  wire logic        master_clock_in,
  // Sample link, own clock domain
  input  wire logic        sample_bit_clock_in,
  input  wire logic        frame_sync_in,
  input  wire logic [14:0] tx_sample_in,
  output logic             serial_sample_out,
  output logic             serial_sample_oe_out,
  // Analog path controls
  output logic             powered_out,
  output logic             diff_earphone_output_en_out,
  output logic             single_ended_earphone_output_en_out,
  output logic             earphone_mute_out,
  output logic             microphone_silence_out,
  output logic             sidetone_mute_out,
  output logic      [2:0]  sidetone_gain_code_out,
  // Gain decode
  output logic             transmit_gain_stage_extended_out,
  output logic      [2:0]  transmit_gain_stage_step_out,
  output logic             tx_gain_valid_out,
  output logic      [4:0]  rx_voice_gain_db_out,
  output logic             rx_voice_valid_out,
  output logic      [4:0]  rx_tone_gain_db_out,
  output logic             tone_mode_out
);

  localparam int LW = $clog2(MCLK_LOSS_CYCLES + 1);
  localparam int DW = $clog2(DRAIN_HOLD_CYCLES + 1);
  localparam logic [LW-1:0] LOSS_MAX = LW'(MCLK_LOSS_CYCLES);
  localparam logic [DW-1:0] HOLD_MAX = DW'(DRAIN_HOLD_CYCLES);

  //////////////////////////////////////////////////////////////////////////////
  // Companding encoder
  function automatic logic [7:0] compand(input logic [14:0] x, input logic alaw);
    logic        sgn;
    logic [14:0] mag;
    logic [12:0] mu;
    logic [11:0] a;
    logic [12:0] tmp;
    logic [2:0]  ex;
    sgn = x[14];
    mag = sgn ? 15'(~x + 15'h0001) : x;
    ex  = 3'h0;
    if (!alaw) begin
      mu = (mag[14:1] > 14'(MU_CLIP)) ? MU_CLIP : mag[13:1];
      mu = mu + MU_BIAS;
      for (int i = 0; i < 8; i++) begin
        if (mu[i+5]) begin
          ex = 3'(i);
        end
      end
      tmp = mu >> ({1'b0, ex} + 4'h1);
      compand = ~{sgn, ex, tmp[3:0]};
    end else begin
      a = (mag[14:2] > 13'(A_CLIP)) ? A_CLIP : mag[13:2];
      for (int i = 1; i < 8; i++) begin
        if (a[i+4]) begin
          ex = 3'(i);
        end
      end
      tmp = (ex == 3'h0) ? 13'(a >> 1) : 13'(a >> ex);
      compand = {~sgn, ex, tmp[3:0]} ^ 8'h55;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Main clock domain state
  typedef struct packed {
    logic             mclk_s1;
    logic             mclk_s2;
    logic             mclk_s3;
    logic [LW-1:0]    idle_cnt;
    logic             busy_s1;
    logic             busy_s2;
    logic [DW-1:0]    hold_cnt;
    pwr_state_t       state;
    logic             link_en;
    logic             fmt_linear;
    logic             fmt_alaw;
    logic [7:0]       pwr_ctrl;
    logic [7:0]       tx_gain;
    logic [7:0]       rx_gain;
    logic [7:0]       format;
    logic             ap_valid;
    logic             ap_write;
    logic [7:0]       ap_addr;
    logic [31:0]      hrdata;
    logic             powered;
    logic             ear_diff;
    logic             ear_single;
    logic             tx_ext;
    logic [2:0]       tx_step;
    logic             tx_ok;
    logic [4:0]       rx_voice;
    logic             rx_ok;
    logic [4:0]       rx_tone;
  } core_state_t;

  // Link domain state
  typedef struct packed {
    logic        en_s1;
    logic        en;
    logic        lin_s1;
    logic        alaw_s1;
    logic [1:0]  fmt_s2;
    logic [1:0]  fmt_s3;
    logic        lin;
    logic        alaw;
    logic        busy;
    logic [3:0]  cnt;
    logic [14:0] shreg;
    logic        dout;
    logic        oe;
  } link_state_t;

  core_state_t st_r;
  core_state_t st_nxt;
  link_state_t lk_r;
  link_state_t lk_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Main clock domain logic
  always_comb begin
    logic       clk_ok;
    logic       lost;
    logic [7:0] stat;
    logic [3:0] tc;
    logic [3:0] rc;
    clk_ok = 1'b0;
    lost   = 1'b0;
    stat   = 8'h00;
    tc     = 4'h0;
    rc     = 4'h0;
    st_nxt = st_r;

    // Master clock activity detector
    st_nxt.mclk_s1 = master_clock_in;
    st_nxt.mclk_s2 = st_r.mclk_s1;
    st_nxt.mclk_s3 = st_r.mclk_s2;
    if (st_r.mclk_s2 != st_r.mclk_s3) begin
      st_nxt.idle_cnt = '0;
    end else if (st_r.idle_cnt != LOSS_MAX) begin
      st_nxt.idle_cnt = st_r.idle_cnt + LW'(1);
    end
    clk_ok = (st_r.idle_cnt != LOSS_MAX);
    lost   = !st_r.tx_gain[TX_CLKDET_OFF_BIT] && !clk_ok;

    st_nxt.busy_s1 = lk_r.busy;
    st_nxt.busy_s2 = st_r.busy_s1;

    // Register writes, accepted in every power state
    if (st_r.ap_valid && st_r.ap_write) begin
      unique case (st_r.ap_addr)
        PWR_CTRL_OFS: st_nxt.pwr_ctrl = hwdata_in[7:0];
        TX_GAIN_OFS:  st_nxt.tx_gain  = hwdata_in[7:0];
        RX_GAIN_OFS:  st_nxt.rx_gain  = hwdata_in[7:0];
        FORMAT_OFS:   st_nxt.format   = {6'h00, hwdata_in[1:0]};
        default:      st_nxt.format   = st_nxt.format;
      endcase
    end

    // Power sequencing
    st_nxt.hold_cnt = '0;
    unique case (st_r.state)
      PWR_OFF: begin
        if (st_r.pwr_ctrl[PWR_ON_BIT] && !lost) begin
          st_nxt.state = PWR_ON;
        end
      end
      PWR_ON: begin
        if (!st_r.pwr_ctrl[PWR_ON_BIT] || lost) begin
          st_nxt.state = PWR_DRAIN;
        end
      end
      PWR_DRAIN: begin
        // Word in flight must finish; hold covers crossing latency
        if (!st_r.busy_s2 && st_r.hold_cnt != HOLD_MAX) begin
          st_nxt.hold_cnt = st_r.hold_cnt + DW'(1);
        end else if (!st_r.busy_s2) begin
          st_nxt.state = PWR_OFF;
        end
      end
    endcase
    st_nxt.link_en    = (st_nxt.state == PWR_ON);
    st_nxt.fmt_linear = st_nxt.format[FMT_LINEAR_BIT];
    st_nxt.fmt_alaw   = st_nxt.format[FMT_ALAW_BIT];

    // Analog controls
    st_nxt.powered    = (st_nxt.state != PWR_OFF);
    st_nxt.ear_diff   = st_nxt.powered && st_nxt.pwr_ctrl[PWR_EAR_DIFF_BIT];
    st_nxt.ear_single = st_nxt.powered && !st_nxt.pwr_ctrl[PWR_EAR_DIFF_BIT];

    // Transmit gain decode
    tc = st_nxt.tx_gain[TX_CODE_LSB +: 4];
    st_nxt.tx_ok   = (tc[2:0] <= TX_STEP_MAX);
    st_nxt.tx_ext  = st_nxt.tx_ok && !tc[3];
    st_nxt.tx_step = st_nxt.tx_ok ? tc[2:0] : 3'h0;

    // Receive gain decode
    rc = st_nxt.rx_gain[RX_CODE_LSB +: 4];
    st_nxt.rx_ok    = (rc <= RX_VOICE_MAX);
    st_nxt.rx_voice = st_nxt.rx_ok ? 5'(5'h06 - {1'b0, rc}) : 5'h00;
    unique case (rc)
      4'h0, 4'h1, 4'h2: st_nxt.rx_tone = 5'h0C;
      4'h3, 4'h4, 4'h5: st_nxt.rx_tone = 5'h06;
      4'h6, 4'h7, 4'h8: st_nxt.rx_tone = 5'h00;
      4'h9, 4'hA, 4'hB: st_nxt.rx_tone = 5'h1A;
      4'hC, 4'hD, 4'hE: st_nxt.rx_tone = 5'h14;
      default:          st_nxt.rx_tone = 5'h00;
    endcase

    // Status word
    stat[STAT_POWERED_BIT] = st_nxt.powered;
    stat[STAT_CLK_OK_BIT]  = clk_ok;
    stat[STAT_BUSY_BIT]    = st_r.busy_s2;
    stat[STAT_TX_OK_BIT]   = st_nxt.tx_ok;
    stat[STAT_RX_OK_BIT]   = st_nxt.rx_ok;
    stat[STAT_DRAIN_BIT]   = (st_nxt.state == PWR_DRAIN);

    // Address phase capture and read data, forwarded from pending write
    st_nxt.ap_valid = hsel_in && htrans_in[1] && hready_in;
    st_nxt.ap_write = hwrite_in;
    st_nxt.ap_addr  = haddr_in[7:0];
    if (st_nxt.ap_valid && !hwrite_in) begin
      unique case (haddr_in[7:0])
        PWR_CTRL_OFS: st_nxt.hrdata = {24'h000000, st_nxt.pwr_ctrl};
        TX_GAIN_OFS:  st_nxt.hrdata = {24'h000000, st_nxt.tx_gain};
        RX_GAIN_OFS:  st_nxt.hrdata = {24'h000000, st_nxt.rx_gain};
        FORMAT_OFS:   st_nxt.hrdata = {24'h000000, st_nxt.format};
        STATUS_OFS:   st_nxt.hrdata = {24'h000000, stat};
        default:      st_nxt.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r          <= '0;
      st_r.state    <= PWR_OFF;
      st_r.pwr_ctrl <= PWR_CTRL_RST;
      st_r.tx_gain  <= TX_GAIN_RST;
      st_r.rx_gain  <= RX_GAIN_RST;
      st_r.format   <= FORMAT_RST;
      st_r.tx_ok    <= 1'b1;
      st_r.tx_step  <= 3'h3;
      st_r.rx_ok    <= 1'b1;
      st_r.rx_voice <= 5'h1C;
      st_r.rx_tone  <= 5'h1A;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: serial sample shifter
  always_comb begin
    logic [14:0] word;
    word   = lk_r.lin ? tx_sample_in : {compand(tx_sample_in, lk_r.alaw), 7'h00};
    lk_nxt = lk_r;
    lk_nxt.en_s1   = st_r.link_en;
    lk_nxt.en      = lk_r.en_s1;
    lk_nxt.lin_s1  = st_r.fmt_linear;
    lk_nxt.alaw_s1 = st_r.fmt_alaw;
    lk_nxt.fmt_s2  = {lk_r.lin_s1, lk_r.alaw_s1};
    lk_nxt.fmt_s3  = lk_r.fmt_s2;
    // Format bits may cross on different edges; take the pair once settled
    if (lk_r.fmt_s2 == lk_r.fmt_s3) begin
      lk_nxt.lin  = lk_r.fmt_s3[1];
      lk_nxt.alaw = lk_r.fmt_s3[0];
    end
    if (lk_r.busy) begin
      // Runs to the last bit regardless of power state
      if (lk_r.cnt != 4'h0) begin
        lk_nxt.dout  = lk_r.shreg[14];
        lk_nxt.shreg = {lk_r.shreg[13:0], 1'b0};
        lk_nxt.cnt   = lk_r.cnt - 4'h1;
      end else begin
        lk_nxt.busy = 1'b0;
        lk_nxt.oe   = 1'b0;
        lk_nxt.dout = 1'b0;
      end
    end else if (frame_sync_in && lk_r.en) begin
      lk_nxt.busy  = 1'b1;
      lk_nxt.oe    = 1'b1;
      lk_nxt.dout  = word[14];
      lk_nxt.shreg = {word[13:0], 1'b0};
      lk_nxt.cnt   = (lk_r.lin ? LINEAR_BITS : COMPAND_BITS) - 4'h1;
    end
  end

  always_ff @(posedge sample_bit_clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hrdata_out    = st_r.hrdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign serial_sample_out    = lk_r.dout;
  assign serial_sample_oe_out = lk_r.oe;
  assign powered_out                         = st_r.powered;
  assign diff_earphone_output_en_out         = st_r.ear_diff;
  assign single_ended_earphone_output_en_out = st_r.ear_single;
  assign earphone_mute_out                   = st_r.pwr_ctrl[PWR_EAR_MUTE_BIT];
  assign microphone_silence_out              = st_r.pwr_ctrl[PWR_MIC_MUTE_BIT];
  assign sidetone_mute_out                   = st_r.pwr_ctrl[PWR_ST_MUTE_BIT];
  assign sidetone_gain_code_out              = st_r.tx_gain[TX_ST_LSB +: 3];
  assign transmit_gain_stage_extended_out = st_r.tx_ext;
  assign transmit_gain_stage_step_out     = st_r.tx_step;
  assign tx_gain_valid_out                = st_r.tx_ok;
  assign rx_voice_gain_db_out             = st_r.rx_voice;
  assign rx_voice_valid_out               = st_r.rx_ok;
  assign rx_tone_gain_db_out              = st_r.rx_tone;
  assign tone_mode_out                    = st_r.rx_gain[RX_TONE_BIT];

endmodule

// ---- bench/codec_chk.sv ----
// Port checker for the voice codec control block
`timescale 1ns/1ps
module codec_chk
  import codec_ctrl_pkg::*;
(
  // Watched ports
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       hreadyout_out,
  input wire logic       hresp_out,
  input wire logic       sample_bit_clock_in,
  input wire logic       serial_sample_out,
  input wire logic       serial_sample_oe_out,
  input wire logic       powered_out,
  input wire logic       diff_earphone_output_en_out,
  input wire logic       single_ended_earphone_output_en_out,
  input wire logic       transmit_gain_stage_extended_out,
  input wire logic [2:0] transmit_gain_stage_step_out,
  input wire logic       tx_gain_valid_out,
  input wire logic [4:0] rx_voice_gain_db_out,
  input wire logic       rx_voice_valid_out,
  input wire logic [4:0] rx_tone_gain_db_out
);
  // Shortest word keeps the output driven eight link cycles
  sequence s_word;
    serial_sample_oe_out [*8];
  endsequence
  sequence s_rst_gain;
    transmit_gain_stage_step_out == 3'h3 && !transmit_gain_stage_extended_out
      && rx_voice_gain_db_out == 5'h1C;
  endsequence
  a_word_min: assert property (@(posedge sample_bit_clock_in) disable iff (!rstn_in)
    $rose(serial_sample_oe_out) |-> s_word) else $error("word cut short");
  a_idle_low: assert property (@(posedge sample_bit_clock_in) disable iff (!rstn_in)
    !serial_sample_oe_out |-> !serial_sample_out) else $error("data while released");
  a_ear_excl: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(diff_earphone_output_en_out && single_ended_earphone_output_en_out))
    else $error("both earphones on");
  a_ear_power: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (diff_earphone_output_en_out || single_ended_earphone_output_en_out) == powered_out)
    else $error("earphone and power disagree");
  a_bus_okay: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hreadyout_out && !hresp_out) else $error("bus not ready");
  a_tx_resv: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !tx_gain_valid_out |-> !transmit_gain_stage_extended_out
      && transmit_gain_stage_step_out == 3'h0) else $error("reserved tx code drives gain");
  a_tx_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tx_gain_valid_out |-> transmit_gain_stage_step_out <= TX_STEP_MAX)
    else $error("tx step out of range");
  a_rx_voice: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rx_voice_valid_out |-> $signed(rx_voice_gain_db_out) <= 6
      && $signed(rx_voice_gain_db_out) >= -6) else $error("rx voice gain out of range");
  a_rx_tone: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rx_tone_gain_db_out inside {5'h0C, 5'h06, 5'h00, 5'h1A, 5'h14})
    else $error("rx tone gain not a step");
  a_rst_gain: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(rstn_in) |-> s_rst_gain) else $error("gain not default after reset");
endmodule

bind voice_codec_power_gain_control codec_chk u_chk (.*);

// ---- bench/link_host.sv ----
// Frame master of the serial sample link
`timescale 1ns/1ps
module link_host (
  // Link pins
  output logic        bclk_out,
  output logic        sync_out,
  output logic [14:0] smp_out,
  input  wire logic   sdo_in,
  input  wire logic   oe_in
);
  initial begin
    bclk_out = 1'b0;
    sync_out = 1'b0;
    smp_out  = 15'h0000;
  end
  // Clock runs only inside frames; lead-in edges carry enable and format across
  task automatic frame(input logic [14:0] s, output logic [14:0] w, output int n);
    w = 15'h0000;
    n = 0;
    smp_out = s;
    repeat (4) begin
      #3 bclk_out = 1'b1;
      #3 bclk_out = 1'b0;
    end
    sync_out = 1'b1;
    #3 bclk_out = 1'b1;
    #1 sync_out = 1'b0;
    #2 bclk_out = 1'b0;
    while (oe_in === 1'b1 && n < 20) begin
      w = {w[13:0], sdo_in};
      n++;
      #3 bclk_out = 1'b1;
      #3 bclk_out = 1'b0;
    end
  endtask
endmodule

// ---- bench/test_voice_codec_power_gain_control.sv ----
// Self-checking testbench of the voice codec control block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_voice_codec_power_gain_control
  import codec_ctrl_pkg::*;
;
  logic        clk_in = 1'b0, rstn_in = 1'b0, hwrite = 1'b0, mclk = 1'b0, mrun = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hready, pwr, dif, se, mic, ext, tv, rv, tone, sdo, oe, bclk, fsync, emu, smu;
  logic [2:0]  step, stc;
  logic [4:0]  rvd, rtd;
  logic [14:0] smp;
  int          err_count = 0, checked = 0;

  voice_codec_power_gain_control #(.MCLK_LOSS_CYCLES(8), .DRAIN_HOLD_CYCLES(8)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(1'b1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
    .master_clock_in(mclk), .sample_bit_clock_in(bclk), .frame_sync_in(fsync),
    .tx_sample_in(smp), .serial_sample_out(sdo), .serial_sample_oe_out(oe),
    .powered_out(pwr), .diff_earphone_output_en_out(dif),
    .single_ended_earphone_output_en_out(se), .earphone_mute_out(emu),
    .microphone_silence_out(mic), .sidetone_mute_out(smu), .sidetone_gain_code_out(stc),
    .transmit_gain_stage_extended_out(ext), .transmit_gain_stage_step_out(step),
    .tx_gain_valid_out(tv), .rx_voice_gain_db_out(rvd), .rx_voice_valid_out(rv),
    .rx_tone_gain_db_out(rtd), .tone_mode_out(tone));
  link_host lnk (.bclk_out(bclk), .sync_out(fsync), .smp_out(smp), .sdo_in(sdo),
    .oe_in(oe));

  initial forever #5 clk_in = ~clk_in;
  always #8 if (mrun) mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_in);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    #1;
  endtask

  task automatic wait_pwr(input logic v);
    for (int i = 0; i < 100 && pwr !== v; i++) @(posedge clk_in);
    #1 `CHK(pwr, v)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, PWR_CTRL_OFS, 32'h0, q); `CHK(q, 32'h00000000)
    bus(1'b0, TX_GAIN_OFS, 32'h0, q); `CHK(q, 32'h0000000B)
    bus(1'b0, RX_GAIN_OFS, 32'h0, q); `CHK(q, 32'h0000000A)
    bus(1'b0, FORMAT_OFS, 32'h0, q); `CHK(q, 32'h00000000)
    bus(1'b0, 8'h14, 32'h0, q); `CHK(q, 32'h00000000)
    `CHK({ext, step, rvd, rtd}, 14'h0F9A)
  endtask

  task automatic t_gain();
    logic v;
    for (int c = 0; c < 16; c++) begin
      v = c[2:0] < 3'h6;
      wr(TX_GAIN_OFS, 32'(c) | 32'h70);
      `CHK({stc, tv, ext, step}, {3'h7, v, v & ~c[3], v ? c[2:0] : 3'h0})
      wr(RX_GAIN_OFS, 32'(c) | 32'h10);
      `CHK({tone, rv, rvd}, {1'b1, c < 13, c < 13 ? 5'(6 - c) : 5'h00})
      `CHK(rtd, c < 15 ? 5'(12 - 6 * (c / 3)) : 5'h00)
    end
  endtask

  task automatic t_power();
    logic [31:0] q;
    wr(PWR_CTRL_OFS, 32'hCA);
    `CHK({pwr, mic, emu, smu}, 4'b0111)
    wr(PWR_CTRL_OFS, 32'h03);
    wait_pwr(1'b1);
    `CHK({dif, se, emu, smu}, 4'b1000)
    bus(1'b0, STATUS_OFS, 32'h0, q);
    `CHK(q, 32'((1 << STAT_POWERED_BIT) | (1 << STAT_CLK_OK_BIT)))
    wr(PWR_CTRL_OFS, 32'h01);
    `CHK({dif, se, mic}, 3'b010)
    wr(PWR_CTRL_OFS, 32'h00);
    wait_pwr(1'b0);
    `CHK({dif, se}, 2'b00)
  endtask

  task automatic t_link();
    logic [14:0] w;
    int n;
    wr(FORMAT_OFS, 32'h1);
    wr(PWR_CTRL_OFS, 32'h1);
    wait_pwr(1'b1);
    lnk.frame(15'h4A3C, w, n); `CHK({n[4:0], w}, {5'd15, 15'h4A3C})
    lnk.frame(15'h2001, w, n); `CHK({n[4:0], w}, {5'd15, 15'h2001})
    wr(FORMAT_OFS, 32'h0);
    lnk.frame(15'h0000, w, n); `CHK({n[4:0], w[7:0]}, 13'h08FF)
    lnk.frame(15'h2000, w, n); `CHK({n[4:0], w[7:0]}, 13'h088F)
    wr(FORMAT_OFS, 32'h2);
    lnk.frame(15'h0000, w, n); `CHK({n[4:0], w[7:0]}, 13'h08D5)
    wr(FORMAT_OFS, 32'h1);
    fork
      lnk.frame(15'h1234, w, n);
      begin #40 wr(PWR_CTRL_OFS, 32'h0); end
    join
    `CHK({n[4:0], w}, {5'd15, 15'h1234})
    wait_pwr(1'b0);
  endtask

  task automatic t_mclk();
    logic [14:0] w;
    int n;
    wr(PWR_CTRL_OFS, 32'h1);
    wait_pwr(1'b1);
    mrun = 1'b0;
    wait_pwr(1'b0);
    lnk.frame(15'h0001, w, n); `CHK({n[4:0], oe}, 6'h00)
    wr(PWR_CTRL_OFS, 32'h0);
    mrun = 1'b1;
    wr(TX_GAIN_OFS, 32'h8B);
    wr(PWR_CTRL_OFS, 32'h1);
    wait_pwr(1'b1);
    mrun = 1'b0;
    repeat (40) @(posedge clk_in);
    #1 `CHK(pwr, 1'b1)
    wr(PWR_CTRL_OFS, 32'h0);
    wait_pwr(1'b0);
    mrun = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (RESET_MIN_CYC) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_gain();
    t_power();
    t_link();
    t_mclk();
    conclude();
  end

  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule
